// ### smmd_decoder.sv
// per-subsystem memory map decoder with apb control registers
// Functional notes
// - 384K words: program, data, I/O spaces
// - CPU I/O never reaches DMA I/O
// - two 8K dual-access blocks, two accesses
// - dual-access RAM in data; overlay adds program
// - ten 8K single-access blocks, one access each
// - 4000h-7FFFh data; overlay adds program
// - 8000h-FFFFh program; data-overlay adds data
// - 18000h-1FFFFh program space only
// - program space is four 64K pages
// - external program addresses are 18 bits
// - select pin decides external interface owner
// - data outside on-chip RAM goes external
// - 64K I/O ports with space strobe
// - select pin gates external I/O access
// - mode bit maps page upper halves
`include "smmd_defines.svh"

module smmd_decoder #(
  parameter logic SUBSYS_ID = 1'b0
) (
  // clock and reset
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  // apb slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  input  wire logic [3:0]              pstrb,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  // device pins
  input  wire logic                    subsystem_select,
  input  wire logic                    interface_select_pin,
  input  wire logic                    host_mode_pin,
  // cpu program bus
  input  wire logic                    prog_req,
  input  wire logic [`SMMD_PROG_AW-1:0] prog_addr,
  output logic                         prog_wait,
  // cpu data bus
  input  wire logic                    data_req,
  input  wire logic                    data_we,
  input  wire logic [`SMMD_DATA_AW-1:0] data_addr,
  output logic                         data_wait,
  // cpu port access
  input  wire logic                    port_read_instr,
  input  wire logic                    port_write_instr,
  input  wire logic [`SMMD_IO_AW-1:0]   io_addr,
  output logic                         io_wait,
  // on-chip ram selects
  output logic [`SMMD_N_DUAL_ACCESS_RAM-1:0]     dar_sel_p,
  output logic [`SMMD_N_DUAL_ACCESS_RAM-1:0]     dar_sel_d,
  output logic [`SMMD_BLK_AW-1:0]      dar_addr_p,
  output logic [`SMMD_BLK_AW-1:0]      dar_addr_d,
  output logic [`SMMD_N_SINGLE_ACCESS_RAM-1:0]     sar_sel,
  output logic                         sar_from_data,
  output logic [`SMMD_BLK_AW-1:0]      sar_addr,
  // shared external interface
  output logic                         ext_req,
  output logic [`SMMD_PROG_AW-1:0]     ext_addr,
  output logic                         ext_we,
  output logic [1:0]                   ext_space,
  output logic                         io_space_strobe
);

  // ----------------------------------------
  // decode function
  // ----------------------------------------
  // one function serves both buses so overlaid views hit the same block index
  function automatic smmd_pkg::smmd_hit_t decode(
    input logic        is_prog,
    input logic [17:0] a,
    input logic        overlay_enable,
    input logic        data_overlay_of_program,
    input logic        mp
  );
    smmd_pkg::smmd_hit_t h;
    logic [1:0] page;
    h.kind = smmd_pkg::RG_EXT;
    h.idx  = 4'h0;
    page   = a[17:16];
    if (a[15:14] == 2'b00) begin
      if (!is_prog || overlay_enable) begin
        h.kind = smmd_pkg::RG_DUAL_ACCESS_RAM;
        h.idx  = {3'b000, a[13]};
      end
    end else if (a[15:14] == 2'b01) begin
      if (!is_prog || overlay_enable) begin
        h.kind = smmd_pkg::RG_SINGLE_ACCESS_RAM;
        h.idx  = `SMMD_SAR_LO_BLK + {3'b000, a[13]};
      end
    end else if (!is_prog) begin
      if (data_overlay_of_program) begin
        h.kind = smmd_pkg::RG_SINGLE_ACCESS_RAM;
        h.idx  = `SMMD_SAR_DATA_OVERLAY_OF_PROGRAM_BLK + {2'b00, a[14:13]};
      end
    end else if (!mp) begin
      // upper half internal only while mode bit clear
      // page 1 upper blocks have no data view
      if (page == `SMMD_PAGE_0) begin
        h.kind = smmd_pkg::RG_SINGLE_ACCESS_RAM;
        h.idx  = `SMMD_SAR_DATA_OVERLAY_OF_PROGRAM_BLK + {2'b00, a[14:13]};
      end else if (page == `SMMD_PAGE_1) begin
        h.kind = smmd_pkg::RG_SINGLE_ACCESS_RAM;
        h.idx  = `SMMD_SAR_P1_BLK + {2'b00, a[14:13]};
      end
      // pages 2 and 3 have no upper-half ram and go out
    end
    return h;
  endfunction : decode

  // ----------------------------------------
  // register offset match
  // ----------------------------------------
  function automatic logic reg_at(
    input logic [7:0] a,
    input logic [7:0] ofs
  );
    return a == ofs;
  endfunction : reg_at

  // ----------------------------------------
  // state
  // ----------------------------------------
  smmd_pkg::smmd_state_t st;
  smmd_pkg::smmd_state_t next_st;
  smmd_pkg::smmd_hit_t   ph;
  smmd_pkg::smmd_hit_t   dh;
  logic                  ext_owned;
  logic                  io_req;
  logic                  data_go;
  logic                  data_ext;
  logic                  io_go;
  logic                  prog_go;
  logic                  sar_clash;
  logic                  ext_busy;
  logic                  setup_rd;
  logic                  wr_ctrl;
  logic                  mapped;

  // ----------------------------------------
  // combinational next state
  // ----------------------------------------
  always_comb begin
    next_st = st;
    // page number from the two top address bits
    ph = decode(1'b1, prog_addr, st.overlay_enable, st.data_overlay_of_program, st.mp);
    // data outside on-chip bounds decodes external
    dh = decode(1'b0, {2'b00, data_addr}, st.overlay_enable, st.data_overlay_of_program, st.mp);
    // owner when select matches this subsystem
    // external pins only while interface select high
    ext_owned = interface_select_pin && (subsystem_select == SUBSYS_ID);
    // a non-owner stalls rather than touching the shared pins
    // port access only ever leaves on the external bus
    io_req   = port_read_instr || port_write_instr;
    data_go  = data_req && (dh.kind != smmd_pkg::RG_EXT || ext_owned);
    data_ext = data_go && dh.kind == smmd_pkg::RG_EXT;
    // external I/O only for the owning subsystem
    io_go    = io_req && ext_owned && !data_ext;
    ext_busy = data_ext || io_go;
    // a single-access block takes one access, data first
    // the blocks share one address port, so any two single-access hits clash;
    // this costs program fetches some stalls but never mixes two addresses
    sar_clash = data_go && dh.kind == smmd_pkg::RG_SINGLE_ACCESS_RAM
                && ph.kind == smmd_pkg::RG_SINGLE_ACCESS_RAM;
    // no clash check on dual-access blocks
    prog_go = prog_req && !sar_clash
              && (ph.kind != smmd_pkg::RG_EXT || (ext_owned && !ext_busy));

    // ram selects
    // selects last one cycle, so a block sees each grant once
    next_st.dar_sel_p     = '0;
    next_st.dar_sel_d     = '0;
    next_st.sar_sel       = '0;
    next_st.sar_from_data = 1'b0;
    next_st.dar_addr_p    = prog_addr[12:0];
    next_st.dar_addr_d    = data_addr[12:0];
    next_st.sar_addr      = st.sar_addr;
    // each view drives its own dual-access select; both views share sar_sel
    if (prog_go && ph.kind == smmd_pkg::RG_DUAL_ACCESS_RAM) begin
      next_st.dar_sel_p[ph.idx[0]] = 1'b1;
    end
    if (data_go && dh.kind == smmd_pkg::RG_DUAL_ACCESS_RAM) begin
      next_st.dar_sel_d[dh.idx[0]] = 1'b1;
    end
    if (prog_go && ph.kind == smmd_pkg::RG_SINGLE_ACCESS_RAM) begin
      next_st.sar_sel[ph.idx] = 1'b1;
      next_st.sar_addr        = prog_addr[12:0];
    end
    if (data_go && dh.kind == smmd_pkg::RG_SINGLE_ACCESS_RAM) begin
      next_st.sar_sel[dh.idx] = 1'b1;
      next_st.sar_from_data   = 1'b1;
      next_st.sar_addr        = data_addr[12:0];
    end

    // external bus, data then port then program
    next_st.ext_req   = 1'b0;
    next_st.ext_we    = 1'b0;
    next_st.ext_space = smmd_pkg::SP_NONE;
    next_st.io_strobe = 1'b0;
    if (data_ext) begin
      next_st.ext_req   = 1'b1;
      next_st.ext_addr  = {2'b00, data_addr};
      next_st.ext_we    = data_we;
      next_st.ext_space = smmd_pkg::SP_DATA;
    end else if (io_go) begin
      next_st.ext_req   = 1'b1;
      next_st.ext_addr  = {2'b00, io_addr};
      next_st.ext_we    = port_write_instr;
      next_st.ext_space = smmd_pkg::SP_IO;
      next_st.io_strobe = 1'b1;
    end else if (prog_go && ph.kind == smmd_pkg::RG_EXT) begin
      next_st.ext_req   = 1'b1;
      next_st.ext_addr  = prog_addr;
      next_st.ext_space = smmd_pkg::SP_PROG;
    end

    // apb registers
    mapped   = reg_at(paddr, `SMMD_CTRL_OFS) || reg_at(paddr, `SMMD_STAT_OFS);
    setup_rd = psel && !penable && !pwrite;
    wr_ctrl  = psel && penable && pwrite && pstrb[0] && reg_at(paddr, `SMMD_CTRL_OFS);
    if (setup_rd) begin
      next_st.prdata = '0;
      if (reg_at(paddr, `SMMD_CTRL_OFS)) begin
        next_st.prdata[`SMMD_CTRL_OVERLAY_ENABLE] = st.overlay_enable;
        next_st.prdata[`SMMD_CTRL_DATA_OVERLAY_OF_PROGRAM] = st.data_overlay_of_program;
        next_st.prdata[`SMMD_CTRL_MP]   = st.mp;
      end else if (reg_at(paddr, `SMMD_STAT_OFS)) begin
        next_st.prdata[`SMMD_STAT_OWNED] = ext_owned;
        next_st.prdata[`SMMD_STAT_SEL]   = subsystem_select;
        next_st.prdata[`SMMD_STAT_XIO]   = interface_select_pin;
        next_st.prdata[`SMMD_STAT_STRAP] = st.strap_done;
        next_st.prdata[`SMMD_STAT_MP]    = st.mp;
      end
    end
    if (!st.strap_done) begin
      // mode bit strap caught once, on the first edge after release
      // select low picks the first subsystem
      next_st.mp = interface_select_pin
                   && (!host_mode_pin || subsystem_select == SUBSYS_ID);
      next_st.strap_done = 1'b1;
    end else if (wr_ctrl) begin
      next_st.overlay_enable = pwdata[`SMMD_CTRL_OVERLAY_ENABLE];
      next_st.data_overlay_of_program = pwdata[`SMMD_CTRL_DATA_OVERLAY_OF_PROGRAM];
      next_st.mp   = pwdata[`SMMD_CTRL_MP];
    end

    prog_wait = prog_req && !prog_go;
    data_wait = data_req && !data_go;
    io_wait   = io_req && !io_go;
    // zero-wait slave: no decode here is slow enough to need a wait state
    pready    = 1'b1;
    // unmapped offsets answer with an error and leave every field alone
    pslverr   = psel && penable && !mapped;
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  // spaces stay apart through the space tag on every external access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st            <= '0;
      st.overlay_enable       <= `SMMD_OVERLAY_ENABLE_RST;
      st.data_overlay_of_program       <= `SMMD_DATA_OVERLAY_OF_PROGRAM_RST;
      // mode bit stays clear until the strap edge after release
      st.mp         <= `SMMD_MP_RST;
      st.ext_space  <= smmd_pkg::SP_NONE;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  // every output assigned here comes straight from a flip-flop; the waits, pready and pslverr are combinational
  assign prdata          = st.prdata;
  assign dar_sel_p       = st.dar_sel_p;
  assign dar_sel_d       = st.dar_sel_d;
  assign dar_addr_p      = st.dar_addr_p;
  assign dar_addr_d      = st.dar_addr_d;
  assign sar_sel         = st.sar_sel;
  assign sar_from_data   = st.sar_from_data;
  assign sar_addr        = st.sar_addr;
  assign ext_req         = st.ext_req;
  assign ext_addr        = st.ext_addr;
  assign ext_we          = st.ext_we;
  assign ext_space       = st.ext_space;
  assign io_space_strobe = st.io_strobe;

endmodule : smmd_decoder

// ### smmd_defines.svh
// constants of the subsystem memory map decoder
`ifndef SMMD_DEFINES_SVH
`define SMMD_DEFINES_SVH
// ----------------------------------------
// register offsets and fields
// ----------------------------------------
`define SMMD_CTRL_OFS      8'h00
`define SMMD_STAT_OFS      8'h04
`define SMMD_CTRL_OVERLAY_ENABLE     0
`define SMMD_CTRL_DATA_OVERLAY_OF_PROGRAM     1
`define SMMD_CTRL_MP       2
`define SMMD_STAT_OWNED    0
`define SMMD_STAT_SEL      1
`define SMMD_STAT_XIO      2
`define SMMD_STAT_STRAP    3
`define SMMD_STAT_MP       4
`define SMMD_OVERLAY_ENABLE_RST      1'b0
`define SMMD_DATA_OVERLAY_OF_PROGRAM_RST      1'b0
`define SMMD_MP_RST        1'b0
// ----------------------------------------
// address map
// ----------------------------------------
`define SMMD_PROG_AW       18
`define SMMD_DATA_AW       16
`define SMMD_IO_AW         16
`define SMMD_BLK_AW        13
`define SMMD_N_DUAL_ACCESS_RAM       2
`define SMMD_N_SINGLE_ACCESS_RAM       10
`define SMMD_SAR_LO_BLK    4'h0
`define SMMD_SAR_DATA_OVERLAY_OF_PROGRAM_BLK  4'h2
`define SMMD_SAR_P1_BLK    4'h6
`define SMMD_PAGE_0        2'h0
`define SMMD_PAGE_1        2'h1
`endif

// ### smmd_pkg.sv
// types of the subsystem memory map decoder
package smmd_pkg;
  typedef enum logic [1:0] {RG_DUAL_ACCESS_RAM, RG_SINGLE_ACCESS_RAM, RG_EXT} smmd_region_t;
  typedef enum logic [1:0] {SP_NONE, SP_PROG, SP_DATA, SP_IO} smmd_space_t;

  typedef struct packed {
    smmd_region_t kind;
    logic [3:0]   idx;
  } smmd_hit_t;

  typedef struct packed {
    logic        overlay_enable;
    logic        data_overlay_of_program;
    logic        mp;
    logic        strap_done;
    logic [31:0] prdata;
    logic [1:0]  dar_sel_p;
    logic [1:0]  dar_sel_d;
    logic [12:0] dar_addr_p;
    logic [12:0] dar_addr_d;
    logic [9:0]  sar_sel;
    logic        sar_from_data;
    logic [12:0] sar_addr;
    logic        ext_req;
    logic [17:0] ext_addr;
    logic        ext_we;
    smmd_space_t ext_space;
    logic        io_strobe;
  } smmd_state_t;
endpackage : smmd_pkg

// ### smmd_ext_model.sv
// far side model: select pins and a count of external accesses
module smmd_ext_model (
  // clock and reset
  input  logic       pclk,
  input  logic       presetn,
  // bench controls
  input  logic       give_second,
  input  logic       ext_enable,
  // decoder side
  input  logic       ext_req,
  output logic       subsystem_select,
  output logic       interface_select_pin,
  output logic [7:0] access_count
);
  assign subsystem_select = give_second;
  assign interface_select_pin = ext_enable;
  // a request left standing shows up as extra counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      access_count <= 8'h00;
    else if (ext_req)
      access_count <= access_count + 8'h01;
  end
endmodule : smmd_ext_model

// ### smmd_decoder_assertions.sv
// port-level assertions for the memory map decoder
module smmd_checker #(
  parameter logic SUBSYS_ID = 1'b0
) (
  // clock, reset and select pin
  input logic        pclk,
  input logic        presetn,
  input logic        subsystem_select,
  // cpu requests
  input logic        prog_req,
  input logic [17:0] prog_addr,
  input logic        prog_wait,
  input logic        data_req,
  input logic [15:0] data_addr,
  input logic        data_wait,
  input logic        port_read_instr,
  input logic [15:0] io_addr,
  input logic        io_wait,
  // decoded outputs
  input logic [1:0]  dar_sel_d,
  input logic [9:0]  sar_sel,
  input logic        sar_from_data,
  input logic        ext_req,
  input logic [17:0] ext_addr,
  input logic [1:0]  ext_space,
  input logic        io_space_strobe
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_data_dual_access_ram: assert property (data_req && !data_wait && data_addr < 16'h4000
    |=> dar_sel_d == (2'h1 << $past(data_addr[13]))) else $error("bad dual-access select");
  a_data_single_access_ram: assert property (data_req && !data_wait && data_addr[15:14] == 2'b01
    |=> sar_from_data && sar_sel == (10'h001 << $past(data_addr[13])))
    else $error("bad low single-access select");
  a_data_no_hi: assert property (sar_from_data |-> sar_sel[9:6] == 4'h0)
    else $error("data reached a program-only block");
  a_page_ext: assert property (prog_req && !prog_wait && prog_addr[17] && prog_addr[15]
    |=> ext_req && ext_space == 2'h1 && ext_addr == $past(prog_addr))
    else $error("upper half of page 2 or 3 not external");
  a_port_out: assert property (port_read_instr && !io_wait
    |=> io_space_strobe && ext_space == 2'h3 && ext_addr == {2'h0, $past(io_addr)})
    else $error("port access not sent to io space");
  a_port_owner: assert property (port_read_instr && subsystem_select != SUBSYS_ID
    |-> io_wait) else $error("port access granted to non-owner");
  a_ext_owner: assert property (subsystem_select != SUBSYS_ID |=> !ext_req)
    else $error("non-owner raised an external request");
  a_strobe_io: assert property (io_space_strobe |-> ext_req && ext_space == 2'h3)
    else $error("io strobe outside an io access");
  c_dual_access_ram: cover property (dar_sel_d != 2'h0);
  c_prog_ext: cover property (ext_req && ext_space == 2'h1);
  c_port: cover property (io_space_strobe);
  c_data_ext: cover property (ext_req && ext_space == 2'h2);
endmodule : smmd_checker

bind smmd_decoder smmd_checker #(.SUBSYS_ID(SUBSYS_ID)) u_chk (
  .pclk, .presetn, .subsystem_select, .prog_req, .prog_addr, .prog_wait, .data_req,
  .data_addr, .data_wait, .port_read_instr, .io_addr, .io_wait, .dar_sel_d, .sar_sel,
  .sar_from_data, .ext_req, .ext_addr, .ext_space, .io_space_strobe
);

// ### tb.sv
// self-checking bench for the memory map decoder
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        prog_req = 1'b0, data_req = 1'b0, port_read_instr = 1'b0, wt;
  logic        data_we = 1'b0, port_write_instr = 1'b0, sar_from_data, ext_we;
  logic [12:0] dar_addr_p, dar_addr_d, sar_addr;
  logic        give_second = 1'b0, ext_enable = 1'b1, host_mode_pin = 1'b1;
  logic        pready, pslverr, subsystem_select, interface_select_pin, prog_wait;
  logic        data_wait, io_wait, ext_req, io_space_strobe;
  logic [7:0]  paddr = 8'h00, access_count, n;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [17:0] prog_addr = 18'h0, ext_addr;
  logic [15:0] data_addr = 16'h0, io_addr = 16'h0;
  logic [1:0]  dar_sel_p, dar_sel_d, ext_space;
  logic [9:0]  sar_sel;
  int          failures = 0, checks = 0;

  smmd_decoder #(.SUBSYS_ID(1'b0)) u_dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata,
    .pready, .pslverr, .subsystem_select, .interface_select_pin, .host_mode_pin, .prog_req,
    .prog_addr, .prog_wait, .data_req, .data_we, .data_addr, .data_wait,
    .port_read_instr, .port_write_instr, .io_addr, .io_wait, .dar_sel_p, .dar_sel_d,
    .dar_addr_p, .dar_addr_d, .sar_sel, .sar_from_data, .sar_addr, .ext_req,
    .ext_addr, .ext_we, .ext_space, .io_space_strobe
  );
  smmd_ext_model u_far (
    .pclk, .presetn, .give_second, .ext_enable, .ext_req, .subsystem_select,
    .interface_select_pin, .access_count
  );
  initial begin
    forever #2.5 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: saw %h, want %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    wt = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  function automatic logic [17:0] ex(logic [1:0] sp, logic [1:0] dp, logic [1:0] dd,
                                     logic [9:0] s);
    return {sp != 2'h0, sp, sp == 2'h3, dp, dd, s};
  endfunction : ex

  // one request for one cycle; kind 0 data read, 1 program, 2 port read,
  // 3 port write, 4 data write
  task automatic cpu(input int k, input logic [17:0] a, input logic [17:0] e);
    logic [17:0] o;
    logic        w;
    w = (k == 3 || k == 4);
    data_req <= (k == 0 || k == 4);
    data_we <= (k == 4);
    prog_req <= (k == 1);
    port_read_instr <= (k == 2);
    port_write_instr <= (k == 3);
    {prog_addr, data_addr, io_addr} <= {a, a[15:0], a[15:0]};
    @(posedge pclk);
    wt = (k == 0 || k == 4) ? data_wait : (k == 1) ? prog_wait : io_wait;
    {data_req, data_we, prog_req, port_read_instr, port_write_instr} <= 5'b00000;
    #1;
    o = {ext_req, ext_space, io_space_strobe, dar_sel_p, dar_sel_d, sar_sel};
    chk({14'h0, o}, {14'h0, e});
    chk({6'h0, dar_addr_p, dar_addr_d}, {6'h0, a[12:0], a[12:0]});
    if (e[9:0] != 10'h0) begin
      chk({19'h0, sar_addr}, {19'h0, a[12:0]});
      chk({31'h0, sar_from_data}, {31'h0, k == 0 || k == 4});
    end
    if (e[17]) begin
      chk({14'h0, ext_addr}, {14'h0, a});
      chk({31'h0, ext_we}, {31'h0, w});
    end
    @(posedge pclk);
  endtask : cpu

  task automatic s_strap_regs();
    apb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h4);
    apb(1'b0, 8'h04, 32'h0);
    chk(q, 32'h1d);
    cpu(1, 18'h08000, ex(2'h1, 2'h0, 2'h0, 10'h0));
    apb(1'b1, 8'h00, 32'h0);
    apb(1'b1, 8'h08, 32'h7);
    chk({31'h0, wt}, 32'h1);
    apb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0);
    cpu(1, 18'h08000, ex(2'h0, 2'h0, 2'h0, 10'h004));
  endtask : s_strap_regs

  task automatic s_map();
    cpu(0, 18'h01000, ex(2'h0, 2'h0, 2'h1, 10'h0));
    cpu(1, 18'h00000, ex(2'h1, 2'h0, 2'h0, 10'h0));
    cpu(1, 18'h04000, ex(2'h1, 2'h0, 2'h0, 10'h0));
    cpu(0, 18'h03fff, ex(2'h0, 2'h0, 2'h2, 10'h0));
    cpu(0, 18'h07fff, ex(2'h0, 2'h0, 2'h0, 10'h002));
    cpu(0, 18'h08000, ex(2'h2, 2'h0, 2'h0, 10'h0));
    cpu(4, 18'h0c000, ex(2'h2, 2'h0, 2'h0, 10'h0));
    cpu(1, 18'h1ffff, ex(2'h0, 2'h0, 2'h0, 10'h200));
    cpu(1, 18'h38000, ex(2'h1, 2'h0, 2'h0, 10'h0));
    apb(1'b1, 8'h00, 32'h3);
    cpu(0, 18'h0e000, ex(2'h0, 2'h0, 2'h0, 10'h020));
    cpu(1, 18'h25000, ex(2'h0, 2'h0, 2'h0, 10'h001));
    cpu(1, 18'h13000, ex(2'h0, 2'h2, 2'h0, 10'h0));
    cpu(0, 18'h03000, ex(2'h0, 2'h0, 2'h2, 10'h0));
  endtask : s_map

  task automatic s_port();
    n = access_count;
    cpu(2, 18'h0beef, ex(2'h3, 2'h0, 2'h0, 10'h0));
    #1;
    chk({24'h0, access_count}, {24'h0, n + 8'h01});
    @(posedge pclk);
    cpu(3, 18'h0cafe, ex(2'h3, 2'h0, 2'h0, 10'h0));
    give_second <= 1'b1;
    cpu(2, 18'h01234, 18'h0);
    chk({31'h0, wt}, 32'h1);
    give_second <= 1'b0;
    ext_enable <= 1'b0;
    cpu(2, 18'h01234, 18'h0);
    chk({31'h0, wt}, 32'h1);
    ext_enable <= 1'b1;
  endtask : s_port

  // mid-run reset with the select pin high: the first subsystem straps internal
  task automatic s_reset();
    presetn <= 1'b0;
    give_second <= 1'b1;
    repeat (2) @(posedge pclk);
    chk({19'h0, ext_req, dar_sel_d, sar_sel}, 32'h0);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    apb(1'b0, 8'h00, 32'h0);
    chk(q, 32'h0);
    apb(1'b0, 8'h04, 32'h0);
    chk(q, 32'h0e);
    cpu(1, 18'h08000, ex(2'h0, 2'h0, 2'h0, 10'h004));
    give_second <= 1'b0;
  endtask : s_reset

  task automatic complete_run();
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run

  // whole run is under a hundred cycles
  initial begin
    repeat (5000) @(posedge pclk);
    failures++;
    complete_run();
  end

  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    s_strap_regs();
    s_map();
    s_port();
    s_reset();
    complete_run();
  end
endmodule : tb
